// File: dv/ldc_chk_assertions.sv
// port checker for the lamp dimmer configuration block
`timescale 1ns/100ps
`default_nettype none
module ldc_chk (
    input wire SYS_CLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_OUT,
    input wire SDA_OE,
    input wire OPEN_TUBE_TRIP,
    input wire LATCH_SELECT_PIN,
    input wire POWER_DOWN_N,
    input wire LAMP_STANDBY_N,
    input wire [4:0] ACTIVE_DIM_CODE,
    input wire SOFT_START_CLAMP,
    input wire SWITCH_ENABLE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_shdn;
        !POWER_DOWN_N |-> !SWITCH_ENABLE && SOFT_START_CLAMP;
    endproperty
    a_shdn: assert property (p_shdn) else $error("switch on in shutdown");
    property p_stby;
        !LAMP_STANDBY_N |-> !SWITCH_ENABLE && SOFT_START_CLAMP;
    endproperty
    a_stby: assert property (p_stby) else $error("switch on in standby");
    property p_dim0;
        ACTIVE_DIM_CODE == 5'h00 |-> SOFT_START_CLAMP;
    endproperty
    a_dim0: assert property (p_dim0) else $error("no clamp at code 0");
    property p_run;
        (!OPEN_TUBE_TRIP) [*8] ##0 (POWER_DOWN_N && LAMP_STANDBY_N)
            |-> SWITCH_ENABLE;
    endproperty
    a_run: assert property (p_run) else $error("switch off when run");
    property p_trip;
        OPEN_TUBE_TRIP [*7] |-> !SWITCH_ENABLE;
    endproperty
    a_trip: assert property (p_trip) else $error("switch on in trip");
    // dim code and power-down only move on a select change or a load in scl low
    property p_hold;
        (SCL_IN && $stable(LATCH_SELECT_PIN)) [*8]
            |-> $stable(ACTIVE_DIM_CODE) && $stable(POWER_DOWN_N);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved");
    property p_oe;
        $changed(SDA_OE) |-> !(SCL_IN && $past(SCL_IN, 2));
    endproperty
    a_oe: assert property (p_oe) else $error("sda moved in scl high");
    property p_od;
        SDA_OE |-> !SDA_OUT;
    endproperty
    a_od: assert property (p_od) else $error("sda driven high");
endmodule
bind ldc_top ldc_chk u_chk (.SYS_CLK, .RST, .SCL_IN, .SDA_OUT, .SDA_OE,
    .OPEN_TUBE_TRIP, .LATCH_SELECT_PIN, .POWER_DOWN_N, .LAMP_STANDBY_N,
    .ACTIVE_DIM_CODE, .SOFT_START_CLAMP, .SWITCH_ENABLE);
`default_nettype wire

// File: dv/ldc_host.sv
// smbus host model: drives scl and pulls sda low
`timescale 1ns/100ps
`default_nettype none
module ldc_host (
    input wire logic clk,
    input wire logic sda,
    output var logic scl,
    output var logic pull
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start();
        pull <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask
    // data moves one cycle after the fall so it never looks like a stop
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        pull <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(2);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, ack);
    endtask
    task automatic stop();
        tick(1);
        pull <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(8);
        pull <= 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench with a behavioural latch model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic clk, rst, sel, trip, scl, pull, oe, so, pdn, stby, clamp, sw;
    logic [4:0] code;
    logic [6:0] lat0 = 7'h10, lat1 = 7'h70;
    logic otp = 1'b1;
    int n_errors = 0, n_tests = 0, r;
    wire sda;
    assign sda = ~(pull | (oe & ~so));
    ldc_host host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    ldc_top dut (.SYS_CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(so), .SDA_OE(oe), .LATCH_SELECT_PIN(sel),
        .OPEN_TUBE_TRIP(trip), .POWER_DOWN_N(pdn), .LAMP_STANDBY_N(stby),
        .ACTIVE_DIM_CODE(code), .SOFT_START_CLAMP(clamp),
        .SWITCH_ENABLE(sw));
    task automatic stop_test();
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_out();
        logic [6:0] s;
        repeat (12) @(posedge clk);
        s = sel ? lat1 : lat0;
        if (!s[6] || !s[5])
            otp = 1'b1;
        `CHK(pdn, s[6])
        `CHK(stby, s[5])
        `CHK(code, s[4:0])
        `CHK(sw, s[6] & s[5] & ~trip)
        `CHK(clamp, ~(s[6] & s[5]) | (s[4:0] == 5'h00))
    endtask
    task automatic wr(input logic [6:0] adr, input logic [7:0] d,
        input logic extra);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer({adr, 1'b0}, q, a);
        `CHK(a, adr != 7'h2d)
        if (!a) begin
            host.xfer(d, q, a);
            `CHK(a, 1'b0)
            if (d[7])
                lat1 = d[6:0];
            else
                lat0 = d[6:0];
            // surplus bytes must neither ack nor load
            if (extra) begin
                host.xfer(~d, q, a);
                `CHK(a, 1'b1)
            end
        end
        host.stop();
        check_out();
    endtask
    task automatic rd();
        logic [7:0] q, e;
        logic a;
        e = {otp, 2'b11, (sel ? lat1[4:0] : lat0[4:0])};
        host.start();
        host.xfer({7'h2d, 1'b1}, q, a);
        `CHK(a, 1'b0)
        host.xfer(8'hff, q, a);
        `CHK(q, e)
        host.stop();
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        sel = 1'b0;
        trip = 1'b0;
        r = $urandom(32'h7d940a5e);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        check_out();
        rd();
        sel <= 1'b1;
        check_out();
        rd();
        wr(7'h2d, 8'h05, 1'b1);
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            sel <= r[8];
            wr(r[10:9] == 2'b00 ? r[17:11] : 7'h2d, r[7:0], r[20]);
            rd();
        end
        sel <= 1'b0;
        wr(7'h2d, 8'h7f, 1'b0);
        trip <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(sw, 1'b0)
        trip <= 1'b0;
        otp = 1'b0;
        check_out();
        rd();
        // shutdown entry must keep the bus alive and re-arm the flag
        wr(7'h2d, 8'h1f, 1'b0);
        rd();
        wr(7'h2d, 8'h40, 1'b0);
        wr(7'h2d, 8'h7f, 1'b0);
        // zero code must clamp soft start even with the lamp enabled
        wr(7'h2d, 8'h60, 1'b0);
        rd();
        // latch one governs while the pin is high, shutdown included
        sel <= 1'b1;
        wr(7'h2d, 8'h9f, 1'b0);
        rd();
        wr(7'h2d, 8'hff, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire

// File: hdl/ldc_cfg_latch.v
// one 7-bit configuration latch with its own power-up value
`timescale 1ns/100ps
`default_nettype none

module ldc_cfg_latch #(
    parameter [6:0] RST_VAL = 7'h00
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [6:0] din,
    output reg [6:0] q
);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        q <= RST_VAL;
    end else if (load) begin
        q <= din;
    end
end

endmodule

`default_nettype wire

// File: hdl/ldc_sync.v
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none

module ldc_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire din,
    output reg level,
    output wire rise,
    output wire fall
);

// ****************************************
// stages
// ****************************************
reg ff1;
reg ff2;
reg ff3;

// a change is taken only once stages two and three agree
wire agree = (ff2 == ff3);

assign rise = agree & ff3 & ~level;
assign fall = agree & ~ff3 & level;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ff1 <= RST_VAL;
        ff2 <= RST_VAL;
        ff3 <= RST_VAL;
        level <= RST_VAL;
    end else begin
        ff1 <= din;
        ff2 <= ff1;
        ff3 <= ff2;
        if (agree) begin
            level <= ff3;
        end
    end
end

endmodule

`default_nettype wire

// File: hdl/ldc_top.v
// smbus configuration interpreter of the lamp dimmer
//
// Operation
// - two separate 7-bit configuration latches, only one governs the lamp
// - respond only to slave address 0101101
// - select pin picks the governing latch, low picks latch zero
// - byte bit 7 zero loads bits 6..0 into latch zero only
// - latch bit 6 zero means full shutdown, one means normal operation
// - shutdown bit overrides the standby bit
// - standby bit zero forces switch off and clamps soft start
// - standby bit one runs the lamp supply normally
// - latch bits 4..0 form the 5-bit brightness code
// - latch zero powers up as shutdown, standby, code 10000
// - byte bit 7 one loads bits 6..0 into latch one
// - host reads the status byte with a read transaction
// - status: open-tube flag bit 7, ones bits 6..5, code 4..0
// - serial interface and latches keep working during shutdown
`timescale 1ns/100ps
`default_nettype none
`include "ldc_regs.vh"

module ldc_top (
    input wire SYS_CLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    input wire LATCH_SELECT_PIN,
    input wire OPEN_TUBE_TRIP,
    output reg POWER_DOWN_N,
    output reg LAMP_STANDBY_N,
    output reg [4:0] ACTIVE_DIM_CODE,
    output reg SOFT_START_CLAMP,
    output reg SWITCH_ENABLE
);

// ****************************************
// states
// ****************************************
localparam [7:0] ST_IDLE = 8'h01;
localparam [7:0] ST_ADDR = 8'h02;
localparam [7:0] ST_AACK = 8'h04;
localparam [7:0] ST_WDAT = 8'h08;
localparam [7:0] ST_WACK = 8'h10;
localparam [7:0] ST_RDAT = 8'h20;
localparam [7:0] ST_RACK = 8'h40;
localparam [7:0] ST_SKIP = 8'h80;

// ****************************************
// pin synchronisers
// ****************************************
wire scl;
wire scl_rise;
wire scl_fall;
wire sda;
wire sda_rise;
wire sda_fall;
wire sel;
wire trip;

ldc_sync #(.RST_VAL(1'b1)) u_scl (
    .clk(SYS_CLK),
    .rst(RST),
    .din(SCL_IN),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
);

ldc_sync #(.RST_VAL(1'b1)) u_sda (
    .clk(SYS_CLK),
    .rst(RST),
    .din(SDA_IN),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
);

ldc_sync #(.RST_VAL(1'b0)) u_sel (
    .clk(SYS_CLK),
    .rst(RST),
    .din(LATCH_SELECT_PIN),
    .level(sel),
    .rise(),
    .fall()
);

ldc_sync #(.RST_VAL(1'b0)) u_trip (
    .clk(SYS_CLK),
    .rst(RST),
    .din(OPEN_TUBE_TRIP),
    .level(trip),
    .rise(),
    .fall()
);

// ****************************************
// bus conditions
// ****************************************
// sda edges with scl steady high are start and stop, never data
wire start_cond = sda_fall & scl & ~scl_fall;
wire stop_cond = sda_rise & scl & ~scl_fall;

// ****************************************
// configuration latches
// ****************************************
reg [1:0] wr_load;
reg [6:0] wr_data;
wire [6:0] latch_q [0:1];

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_latch
        localparam [6:0] RV = (g == 0) ? `LDC_L0_RST : `LDC_L1_RST;
        ldc_cfg_latch #(.RST_VAL(RV)) u_latch (
            .clk(SYS_CLK),
            .rst(RST),
            .load(wr_load[g]),
            .din(wr_data),
            .q(latch_q[g])
        );
    end
endgenerate

// the pin picks the governing latch on every cycle
wire [6:0] active = sel ? latch_q[1] : latch_q[0];
wire lamp_on = active[`LDC_PWR_BIT] & active[`LDC_STBY_BIT];
wire [4:0] code = active[`LDC_DIM_MSB:0];

// ****************************************
// open-tube flag
// ****************************************
reg otp_ok;

// trip wins over the re-arm that shutdown or standby gives
always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
        otp_ok <= `LDC_OTP_RST;
    end else if (trip) begin
        otp_ok <= 1'b0;
    end else if (!lamp_on) begin
        otp_ok <= 1'b1;
    end
end

wire [7:0] status = {otp_ok, `LDC_STAT_ONES, code};

// ****************************************
// smbus byte engine
// ****************************************
reg [7:0] state;
reg [3:0] bitcnt;
reg [7:0] shreg;
reg [7:0] txbyte;
reg rw;

function [2:0] bit_index;
    input [3:0] cnt;
    begin
        bit_index = 3'h7 - cnt[2:0];
    end
endfunction

wire byte_done = (bitcnt == `LDC_ACK_BIT);

// runs on its own regardless of shutdown, so the host can wake the lamp
always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
        state <= ST_IDLE;
        bitcnt <= 4'h0;
        shreg <= 8'h00;
        txbyte <= 8'h00;
        rw <= 1'b0;
        SDA_OE <= 1'b0;
        SDA_OUT <= 1'b0;
        wr_load <= 2'h0;
        wr_data <= 7'h00;
    end else begin
        SDA_OUT <= 1'b0;
        wr_load <= 2'h0;
        if (start_cond) begin
            // repeated start is handled like a fresh one
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            SDA_OE <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            SDA_OE <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    SDA_OE <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bitcnt <= 4'h0;
                        rw <= shreg[0];
                        if (shreg[7:1] == `LDC_SLAVE_ADDR) begin
                            state <= ST_AACK;
                            SDA_OE <= 1'b1;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rw == `LDC_RW_READ) begin
                            // snapshot so the byte cannot tear mid-read
                            txbyte <= status;
                            SDA_OE <= ~status[7];
                            state <= ST_RDAT;
                        end else begin
                            SDA_OE <= 1'b0;
                            state <= ST_WDAT;
                        end
                    end
                end
                ST_WDAT: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bitcnt <= 4'h0;
                        wr_data <= shreg[6:0];
                        if (shreg[`LDC_TARGET_BIT]) begin
                            wr_load <= 2'h2;
                        end else begin
                            wr_load <= 2'h1;
                        end
                        SDA_OE <= 1'b1;
                        state <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    // one byte per write; further bytes are not acked
                    if (scl_fall) begin
                        SDA_OE <= 1'b0;
                        state <= ST_SKIP;
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            bitcnt <= 4'h0;
                            SDA_OE <= 1'b0;
                            state <= ST_RACK;
                        end else begin
                            SDA_OE <= ~txbyte[bit_index(bitcnt)];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        state <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    SDA_OE <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    SDA_OE <= 1'b0;
                end
            endcase
        end
    end
end

// ****************************************
// lamp control outputs
// ****************************************
// registered for clean pins; costs one cycle after the select settles
always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
        POWER_DOWN_N <= 1'b0;
        LAMP_STANDBY_N <= 1'b0;
        ACTIVE_DIM_CODE <= 5'h10;
        SOFT_START_CLAMP <= 1'b1;
        SWITCH_ENABLE <= 1'b0;
    end else begin
        POWER_DOWN_N <= active[`LDC_PWR_BIT];
        LAMP_STANDBY_N <= active[`LDC_STBY_BIT];
        ACTIVE_DIM_CODE <= code;
        SOFT_START_CLAMP <= ~lamp_on | (code == `LDC_DIM_ZERO);
        SWITCH_ENABLE <= lamp_on & ~trip;
    end
end

endmodule

`default_nettype wire

// File: inc/ldc_regs.vh
// constants of the lamp dimmer smbus configuration block
`ifndef LDC_REGS_VH
`define LDC_REGS_VH

// ****************************************
// bus address and byte layout
// ****************************************
`define LDC_SLAVE_ADDR 7'h2d
`define LDC_RW_READ 1'b1
`define LDC_ACK_BIT 4'h8
`define LDC_TARGET_BIT 7
`define LDC_PWR_BIT 6
`define LDC_STBY_BIT 5
`define LDC_DIM_MSB 4
`define LDC_DIM_ZERO 5'h00

// ****************************************
// reset values
// ****************************************
`define LDC_L0_RST 7'h10
`define LDC_L1_RST 7'h70
`define LDC_OTP_RST 1'b1

// ****************************************
// status byte
// ****************************************
`define LDC_STAT_OTP_BIT 7
`define LDC_STAT_ONES 2'h3

`endif
